// file: src/ddpc_codec.sv
// Dibit differential phase encoder and decoder
// How it works
// - Transmit bits are taken in non-overlapping pairs, one pair per symbol.
// - Each symbol adds a step to the previous phase, never absolute.
// - First bit of each pair is the dibit's left-hand bit.
// - Option A steps: 00 none, 01 +90, 11 +180, 10 +270.
// - Option B steps: 00 +45, 01 +135, 11 +225, 10 +315.
// - Receiver maps steps back to dibits and sends bits in order.
// - From request-to-send on until ready-for-sending on, send dibit 11.
// - Eight phase states, one symbol per period, no start or stop.
// - Transmit and receive paths run together, full duplex; each rx second bit waits for the tx bit tick.
// - 2400 bit/s, 1200 symbols per second, two bits per symbol.
`timescale 1ns/10ps
`include "ddpc_consts.svh"

module ddpc_codec #(
  parameter int BIT_DIV = `DDPC_BIT_DIV
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire ddpc_pkg::ddpc_map_t map_sel,
  input wire logic rts_in,
  input wire logic rfs_in,
  input wire logic tx_data_in,
  output logic tx_bit_tick,
  output ddpc_pkg::ddpc_phase_t tx_phase_q,
  output logic tx_sym_strobe_q,
  input wire ddpc_pkg::ddpc_phase_t rx_step_in,
  input wire logic rx_step_valid,
  output logic rx_data_q,
  output logic rx_data_valid_q
);
  import ddpc_pkg::*;

  // ************************************
  // Input synchronisers
  // ************************************
  logic [1:0] rts_s_q;
  logic [1:0] rfs_s_q;
  logic [1:0] din_s_q;
  logic [1:0] map_s_q;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rts_s_q <= 2'h0;
      rfs_s_q <= 2'h0;
      din_s_q <= 2'h0;
      map_s_q <= 2'h0;
    end
    else
    begin
      rts_s_q <= {rts_s_q[0], rts_in};
      rfs_s_q <= {rfs_s_q[0], rfs_in};
      din_s_q <= {din_s_q[0], tx_data_in};
      map_s_q <= {map_s_q[0], map_sel};
    end
  end

  logic rts;
  logic rfs;
  logic din;
  ddpc_map_t map_mode;
  assign rts = rts_s_q[1];
  assign rfs = rfs_s_q[1];
  assign din = din_s_q[1];
  assign map_mode = ddpc_map_t'(map_s_q[1]);

  // ************************************
  // Step mapping, shared by both paths
  // ************************************
  function automatic ddpc_phase_t dibit_to_step(ddpc_dibit_t d,
                                                ddpc_map_t m);
    ddpc_phase_t s;
    case (d)
      2'h0: s = 3'h0;
      2'h1: s = 3'h2;
      2'h3: s = 3'h4;
      2'h2: s = 3'h6;
      default: s = 3'h0;
    endcase
    if (m == DDPC_MAP_B)
      s = s + 3'h1;
    return s;
  endfunction

  function automatic ddpc_dibit_t step_to_dibit(ddpc_phase_t s,
                                                ddpc_map_t m);
    ddpc_phase_t a;
    ddpc_dibit_t d;
    a = (m == DDPC_MAP_B) ? s - 3'h1 : s;
    // Odd residue rounds down so a noisy step still decodes
    case (a[2:1])
      2'h0: d = 2'h0;
      2'h1: d = 2'h1;
      2'h2: d = 2'h3;
      2'h3: d = 2'h2;
      default: d = 2'h0;
    endcase
    return d;
  endfunction

  // ************************************
  // Bit rate divider
  // ************************************
  logic [15:0] div_q;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      div_q <= 16'h0000;
    else if (div_q == 16'(BIT_DIV - 1))
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end
  // Truncated divide keeps the rate error far inside the line tolerance
  assign tx_bit_tick = (div_q == 16'(BIT_DIV - 1));

  // ************************************
  // Transmit sequencing
  // ************************************
  ddpc_tx_state_t st_q;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      st_q <= DDPC_IDLE;
    else
      case (st_q)
        DDPC_IDLE: if (rts) st_q <= rfs ? DDPC_DATA : DDPC_SYNC;
        DDPC_SYNC:
        begin
          if (!rts)
            st_q <= DDPC_IDLE;
          else if (rfs)
            st_q <= DDPC_DATA;
        end
        DDPC_DATA: if (!rts) st_q <= DDPC_IDLE;
        default: st_q <= DDPC_IDLE;
      endcase
  end

  // Pair phase toggles every bit tick; two bits form one symbol
  logic half_q;
  logic first_q;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      half_q <= 1'b0;
      first_q <= 1'b0;
    end
    else if (tx_bit_tick)
    begin
      half_q <= ~half_q;
      if (!half_q)
        first_q <= din;
    end
  end

  ddpc_dibit_t tx_dibit;
  always_comb
  begin
    if (st_q == DDPC_SYNC)
      tx_dibit = `DDPC_SYNC_DIBIT;
    else
      tx_dibit = {first_q, din};
  end

  // Line keeps its phase while idle; symbols still clock out
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_phase_q <= `DDPC_PHASE_RST;
      tx_sym_strobe_q <= 1'b0;
    end
    else
    begin
      tx_sym_strobe_q <= tx_bit_tick && half_q;
      if (tx_bit_tick && half_q && st_q != DDPC_IDLE)
        tx_phase_q <= tx_phase_q + dibit_to_step(tx_dibit, map_mode);
    end
  end

  // ************************************
  // Receive path, second bit paced by the transmit bit tick
  // ************************************
  // A new step overrides a pending second bit, so steps must come
  // more than one bit period apart; the tx divider paces the second bit
  logic rx_second_q;
  logic rx_pend_q;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_data_q <= 1'b0;
      rx_data_valid_q <= 1'b0;
      rx_second_q <= 1'b0;
      rx_pend_q <= 1'b0;
    end
    else
    begin
      rx_data_valid_q <= 1'b0;
      if (rx_step_valid)
      begin
        {rx_data_q, rx_second_q} <= step_to_dibit(rx_step_in, map_mode);
        rx_data_valid_q <= 1'b1;
        rx_pend_q <= 1'b1;
      end
      else if (rx_pend_q && tx_bit_tick)
      begin
        rx_data_q <= rx_second_q;
        rx_data_valid_q <= 1'b1;
        rx_pend_q <= 1'b0;
      end
    end
  end
endmodule // ddpc_codec

// file: inc/ddpc_consts.svh
// Constants for the dibit differential phase codec
`ifndef DDPC_CONSTS_SVH
`define DDPC_CONSTS_SVH
`define DDPC_CLK_HZ 25000000
`define DDPC_BIT_RATE 2400
`define DDPC_SYM_RATE 1200
`define DDPC_BIT_DIV (`DDPC_CLK_HZ / `DDPC_BIT_RATE)
`define DDPC_PHASE_W 3
`define DDPC_PHASE_RST 3'h0
`define DDPC_SYNC_DIBIT 2'h3
`endif

// file: inc/ddpc_pkg.sv
// Types for the dibit differential phase codec
package ddpc_pkg;
  typedef logic [1:0] ddpc_dibit_t;
  typedef logic [2:0] ddpc_phase_t;
  typedef enum logic {DDPC_MAP_A, DDPC_MAP_B} ddpc_map_t;
  typedef enum {DDPC_IDLE, DDPC_SYNC, DDPC_DATA} ddpc_tx_state_t;
endpackage

// file: dv/ddpc_codec_assertions.sv
// Port checks for the phase codec
`timescale 1ns/10ps
module ddpc_codec_assertions (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire ddpc_pkg::ddpc_map_t map_sel,
  input wire logic rts_in,
  input wire logic tx_bit_tick,
  input wire ddpc_pkg::ddpc_phase_t tx_phase_q,
  input wire logic tx_sym_strobe_q,
  input wire logic rx_step_valid,
  input wire logic rx_data_valid_q
);
  import ddpc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  moved_a: assert property ($changed(tx_phase_q) |-> tx_sym_strobe_q)
    else $error("phase jump");
  on_tick_a: assert property (tx_sym_strobe_q |-> $past(tx_bit_tick))
    else $error("off tick");
  one_sym_a: assert property (tx_sym_strobe_q |=> !tx_sym_strobe_q)
    else $error("long strobe");
  hold_a: assert property ($past(tx_sym_strobe_q) |-> $stable(tx_phase_q))
    else $error("no hold");
  tick_gap_a: assert property (tx_bit_tick |=> !tx_bit_tick)
    else $error("long tick");
  // Inputs are synchronised: skip strobes near a map change or while idle
  parity_a: assert property (tx_sym_strobe_q && $past(rts_in, 4)
    && map_sel == $past(map_sel, 4)
    |-> (tx_phase_q[0] ^ $past(tx_phase_q[0])) == map_sel)
    else $error("step parity");
  rx_first_a: assert property (rx_step_valid |=> rx_data_valid_q)
    else $error("rx first");
  rx_next_a: assert property (rx_data_valid_q && !$past(rx_step_valid)
    |-> $past(tx_bit_tick)) else $error("rx second");
  cleared_a: assert property (!$past(resetn) |-> tx_phase_q == 3'h0)
    else $error("no clear");
endmodule // ddpc_codec_assertions
bind ddpc_codec ddpc_codec_assertions chk (.*);

// file: dv/ddpc_dte_model.sv
// Serial data source on the terminal side
`timescale 1ns/10ps
module ddpc_dte_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tx_bit_tick,
  input wire ddpc_pkg::ddpc_dibit_t dib,
  output logic tx_data_in
);
  logic half_q;
  // Pairing runs from reset, so the source tracks it too
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      half_q <= 1'h0;
    else if (tx_bit_tick)
      half_q <= ~half_q;
  assign tx_data_in = half_q ? dib[0] : dib[1];
endmodule // ddpc_dte_model

// file: dv/ddpc_codec_test.sv
// Self-checking bench for the phase codec
`timescale 1ns/10ps
module ddpc_codec_test;
  import ddpc_pkg::*;
  logic ref_clk = 1'h0, resetn = 1'h0, rts_in = 1'h0, rfs_in = 1'h0;
  logic rx_step_valid = 1'h0, tx_data_in, tx_bit_tick;
  logic tx_sym_strobe_q, rx_data_q, rx_data_valid_q;
  ddpc_map_t map_sel = DDPC_MAP_A;
  ddpc_phase_t rx_step_in = 3'h0, tx_phase_q, p, d;
  ddpc_dibit_t dib = 2'h0;
  int n_errors = 0, checks_done = 0, cyc = 0, gap = 0;
  localparam int DIV = 4;
  // Step per row, indexed by {option, dibit}
  ddpc_phase_t stp [8] = '{3'h0, 3'h2, 3'h6, 3'h4, 3'h1, 3'h3, 3'h7, 3'h5};
  ddpc_codec #(.BIT_DIV(DIV)) uut (.*);
  ddpc_dte_model dte (.*);
  always #20 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (++cyc == 3000) complete_run(1);
  task automatic chk(input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %0t %h %h", $time, seen, exp);
    end
  endtask
  // Third strobe gives a clean step after any input change
  task automatic step();
    repeat (3)
    begin
      p = tx_phase_q;
      gap = 0;
      do
      begin
        @(negedge ref_clk);
        gap++;
      end
      while (tx_sym_strobe_q !== 1'h1);
    end
    d = tx_phase_q - p;
  endtask
  task automatic complete_run(input int late);
    n_errors += late;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge ref_clk);
    resetn = 1'h1;
    chk(tx_phase_q, 3'h0);
    // Ones at the input would step the phase if idle were not held
    dib = 2'h3;
    step();
    chk(d, 3'h0);
    chk(8'(gap), 8'(2 * DIV));
    $display("idle test end");
    dib = 2'h0;
    rts_in = 1'h1;
    step();
    chk(d, 3'h4);
    $display("sync test end");
    rfs_in = 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      map_sel = ddpc_map_t'(i / 4);
      dib = i[1:0];
      step();
      chk(d, stp[i]);
      rx_step_in = stp[i];
      rx_step_valid = 1'h1;
      @(negedge ref_clk);
      rx_step_valid = 1'h0;
      chk({rx_data_valid_q, rx_data_q}, {1'h1, i[1]});
      do @(negedge ref_clk); while (rx_data_valid_q !== 1'h1);
      chk(rx_data_q, i[0]);
    end
    $display("row tests end");
    resetn = 1'h0;
    @(negedge ref_clk);
    chk(tx_phase_q, 3'h0);
    $display("reset test end");
    complete_run(0);
  end
endmodule // ddpc_codec_test
